// ### core/clock_dist_params.svh
`ifndef CLOCK_DIST_PARAMS_SVH
`define CLOCK_DIST_PARAMS_SVH

// system clock period
`define SYS_CLK_PERIOD_PS     4000
// core clock source divided by this to form the peripheral bus clock
`define BUS_CLK_DIVIDE        2
// timer external clock may run at most at bus clock / this
`define TIMER_EXT_MAX_RATIO   4
// nominal debug fast clock
`define DEBUG_CLK_NOMINAL_MHZ 8

// reset values of held selections and clocks
`define CORE_SEL_RST          2'h0
`define DAY_SEL_RST           2'h0
`define TIMER_SEL_RST         2'h0
`define ADC_SEL_RST           1'h0
`define WDOG_SEL_RST          1'h0
`define DISPLAY_SEL_RST       1'h0
`define CLK_LEVEL_RST         1'h0

`endif

// ### core/clock_dist_pkg.sv
package clock_dist_pkg;

    typedef enum logic [1:0] {
        CORE_INT_REF = 2'h0,
        CORE_EXT_REF = 2'h1,
        CORE_FLL     = 2'h2
    } core_src_t;

    typedef enum logic [1:0] {
        DAY_INT_REF   = 2'h0,
        DAY_LOW_POWER = 2'h1,
        DAY_CRYSTAL   = 2'h2
    } day_src_t;

    typedef enum logic [1:0] {
        TIMER_BUS   = 2'h0,
        TIMER_FIXED = 2'h1,
        TIMER_EXT   = 2'h2
    } timer_src_t;

endpackage : clock_dist_pkg

// ### core/system_clock_distribution.sv
// Contract
// - core source drives cpu clock; half of it forms the peripheral bus clock
// - all peripheral registers are clocked by the peripheral bus clock
// - core source picks internal reference, external reference or fll output
// - debug fast clock from the oscillator, valid only on reference modes
// - external reference clock offered as the alternate adc clock
// - internal reference clock offered as a day counter source
// - fixed clock synchronised to bus clock, selectable for the timers
// - independent low power oscillator selectable for day counter or watchdog
// - crystal clock selectable for day counter and display driver
// - day counter derived clock gated by its enable feeds display alternate
`timescale 1ns/1ps
`include "clock_dist_params.svh"

module system_clock_distribution (
    input  wire logic       CLK_SYS,         // system clock, 250 MHz
    input  wire logic       SYS_RST,         // async reset, active high
    input  wire logic       CE,              // clock enable, freezes all state
    input  wire logic       INT_REF_CLK,     // internal reference clock level
    input  wire logic       EXT_REF_CLK,     // external reference clock level
    input  wire logic       FLL_CLK,         // fll output level
    input  wire logic [1:0] CORE_SRC_SEL,    // core source control bits
    input  wire logic       DIG_OSC_CLK,     // digitally controlled oscillator
    input  wire logic       FIXED_RAW_CLK,   // raw fixed frequency clock
    input  wire logic       LOW_POWER_OSC,   // independent low power oscillator
    input  wire logic       CRYSTAL_OSC,     // crystal oscillator output
    input  wire logic       TIMER_EXT_IN,    // external timer clock pin
    input  wire logic       ADC_EN,          // adc enabled
    input  wire logic       ADC_SRC_SEL,     // 1: external reference clock
    input  wire logic       DAY_EN,          // day counter enabled
    input  wire logic [1:0] DAY_SRC_SEL,     // day counter source
    input  wire logic       DAY_CLK_OUT_EN,  // day counter derived clock enable
    input  wire logic       WDOG_EN,         // watchdog enabled
    input  wire logic       WDOG_SRC_SEL,    // 1: bus clock, 0: low power osc
    input  wire logic       TIMER_EN,        // timer units enabled
    input  wire logic [1:0] TIMER_SRC_SEL,   // timer source
    input  wire logic       DISPLAY_EN,      // display driver enabled
    input  wire logic       DISPLAY_SRC_SEL, // 1: day counter derived clock
    output logic            CPU_CLK,         // cpu clock
    output logic            BUS_CLK,         // peripheral bus clock
    output logic            REG_CLK_EN,      // pulse on each bus clock rise
    output logic            DEBUG_FAST_CLK,  // debug fast clock
    output logic            DEBUG_CLK_VALID, // debug clock usable
    output logic            ADC_ALT_CLK,     // adc conversion clock
    output logic            DAY_CLK,         // day counter clock
    output logic            DAY_OUT_CLK,     // day counter derived clock
    output logic            WDOG_CLK,        // watchdog clock
    output logic            TIMER_CLK,       // timer clock
    output logic            DISPLAY_CLK      // display driver clock
);

    function automatic logic pick3(input logic [1:0] sel, input logic a,
                                   input logic b, input logic c);
        logic r;
        r = a;
        case (sel)
            2'h1:    r = b;
            2'h2:    r = c;
            default: r = a;
        endcase
        return r;
    endfunction : pick3

    // held selections; core_sel follows CORE_SRC_SEL directly
    clock_dist_pkg::core_src_t  core_sel;
    clock_dist_pkg::day_src_t   day_sel_q,   day_sel_d;
    clock_dist_pkg::timer_src_t timer_sel_q, timer_sel_d;
    logic adc_sel_q,  adc_sel_d;
    logic wdog_sel_q, wdog_sel_d;
    logic disp_sel_q, disp_sel_d;

    // clock path state
    logic core_clk;
    logic core_rise;
    logic dbg_ok;
    logic core_prev_q, core_prev_d;
    logic cpu_q,       cpu_d;
    logic bus_q,       bus_d;
    logic regen_q,     regen_d;
    logic dbg_q,       dbg_d;
    logic dbgv_q,      dbgv_d;
    logic adc_q,       adc_d;
    logic ff_s1_q,     ff_s1_d;
    logic ff_s2_q,     ff_s2_d;
    logic fixed_freq_clock_q,     fixed_freq_clock_d;
    logic tx_s1_q,     tx_s1_d;
    logic tx_s2_q,     tx_s2_d;
    logic day_q,       day_d;
    logic dayout_q,    dayout_d;
    logic wdog_q,      wdog_d;
    logic timer_q,     timer_d;
    logic disp_q,      disp_d;

    assign core_sel = clock_dist_pkg::core_src_t'(CORE_SRC_SEL);

    // selections: a live change would glitch the module clock
    always_comb begin
        day_sel_d   = DAY_EN ? day_sel_q
                             : clock_dist_pkg::day_src_t'(DAY_SRC_SEL);
        timer_sel_d = TIMER_EN ? timer_sel_q
                               : clock_dist_pkg::timer_src_t'(TIMER_SRC_SEL);
        adc_sel_d   = ADC_EN ? adc_sel_q : ADC_SRC_SEL;
        wdog_sel_d  = WDOG_EN ? wdog_sel_q : WDOG_SRC_SEL;
        disp_sel_d  = DISPLAY_EN ? disp_sel_q : DISPLAY_SRC_SEL;
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            day_sel_q   <= clock_dist_pkg::day_src_t'(`DAY_SEL_RST);
            timer_sel_q <= clock_dist_pkg::timer_src_t'(`TIMER_SEL_RST);
            adc_sel_q   <= `ADC_SEL_RST;
            wdog_sel_q  <= `WDOG_SEL_RST;
            disp_sel_q  <= `DISPLAY_SEL_RST;
        end else if (CE) begin
            day_sel_q   <= day_sel_d;
            timer_sel_q <= timer_sel_d;
            adc_sel_q   <= adc_sel_d;
            wdog_sel_q  <= wdog_sel_d;
            disp_sel_q  <= disp_sel_d;
        end
    end

    // core source, bus divider and debug clock
    always_comb begin
        core_clk = pick3(core_sel, INT_REF_CLK, EXT_REF_CLK, FLL_CLK);
        core_rise = core_clk & ~core_prev_q;
        dbg_ok = (core_sel == clock_dist_pkg::CORE_INT_REF) ||
                 (core_sel == clock_dist_pkg::CORE_EXT_REF);
        core_prev_d = core_clk;
        cpu_d = core_clk;
        bus_d = core_rise ? ~bus_q : bus_q;
        // register strobe lands on the bus clock rising edge
        regen_d = core_rise & ~bus_q;
        dbgv_d = dbg_ok;
        dbg_d = DIG_OSC_CLK & dbg_ok;
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            core_prev_q <= `CLK_LEVEL_RST;
            cpu_q       <= `CLK_LEVEL_RST;
            bus_q       <= `CLK_LEVEL_RST;
            regen_q     <= 1'h0;
            dbgv_q      <= 1'h0;
            dbg_q       <= `CLK_LEVEL_RST;
        end else if (CE) begin
            core_prev_q <= core_prev_d;
            cpu_q       <= cpu_d;
            bus_q       <= bus_d;
            regen_q     <= regen_d;
            dbgv_q      <= dbgv_d;
            dbg_q       <= dbg_d;
        end
    end

    // peripheral clock routing
    always_comb begin
        adc_d = adc_sel_q ? EXT_REF_CLK : bus_q;
        ff_s1_d = FIXED_RAW_CLK;
        ff_s2_d = ff_s1_q;
        // fixed clock only moves on a bus edge, so it is bus synchronous
        fixed_freq_clock_d = regen_d ? ff_s2_q : fixed_freq_clock_q;
        // two-flop capture only resolves edges slower than bus / 4
        tx_s1_d = TIMER_EXT_IN;
        tx_s2_d = tx_s1_q;
        timer_d = pick3(timer_sel_q, bus_q, fixed_freq_clock_q, tx_s2_q);
        day_d = pick3(day_sel_q, INT_REF_CLK, LOW_POWER_OSC, CRYSTAL_OSC);
        wdog_d = wdog_sel_q ? bus_q : LOW_POWER_OSC;
        dayout_d = day_q & DAY_EN & DAY_CLK_OUT_EN;
        disp_d = disp_sel_q ? dayout_q : CRYSTAL_OSC;
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            adc_q    <= `CLK_LEVEL_RST;
            ff_s1_q  <= `CLK_LEVEL_RST;
            ff_s2_q  <= `CLK_LEVEL_RST;
            fixed_freq_clock_q  <= `CLK_LEVEL_RST;
            tx_s1_q  <= `CLK_LEVEL_RST;
            tx_s2_q  <= `CLK_LEVEL_RST;
            timer_q  <= `CLK_LEVEL_RST;
            day_q    <= `CLK_LEVEL_RST;
            wdog_q   <= `CLK_LEVEL_RST;
            dayout_q <= `CLK_LEVEL_RST;
            disp_q   <= `CLK_LEVEL_RST;
        end else if (CE) begin
            adc_q    <= adc_d;
            ff_s1_q  <= ff_s1_d;
            ff_s2_q  <= ff_s2_d;
            fixed_freq_clock_q  <= fixed_freq_clock_d;
            tx_s1_q  <= tx_s1_d;
            tx_s2_q  <= tx_s2_d;
            timer_q  <= timer_d;
            day_q    <= day_d;
            wdog_q   <= wdog_d;
            dayout_q <= dayout_d;
            disp_q   <= disp_d;
        end
    end

    assign CPU_CLK         = cpu_q;
    assign BUS_CLK         = bus_q;
    assign REG_CLK_EN      = regen_q;
    assign DEBUG_FAST_CLK  = dbg_q;
    assign DEBUG_CLK_VALID = dbgv_q;
    assign ADC_ALT_CLK     = adc_q;
    assign DAY_CLK         = day_q;
    assign DAY_OUT_CLK     = dayout_q;
    assign WDOG_CLK        = wdog_q;
    assign TIMER_CLK       = timer_q;
    assign DISPLAY_CLK     = disp_q;

    // checks; a frozen cycle is excluded
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST || !CE);

    sequence s_core_rise;
        core_rise && CE;
    endsequence

    sequence s_bus_flips;
        ##1 (BUS_CLK != $past(BUS_CLK));
    endsequence

    property p_bus_div;
        s_core_rise |-> s_bus_flips;
    endproperty
    a_bus_div: assert property (p_bus_div) else $error("bus clock missed core edge");

    property p_bus_hold;
        !core_rise && $past(CE) |=> $stable(BUS_CLK);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus clock moved alone");

    property p_cpu_follow;
        CE |=> CPU_CLK == $past(core_clk);
    endproperty
    a_cpu_follow: assert property (p_cpu_follow) else $error("cpu clock wrong");

    property p_reg_strobe;
        // a strobe frozen by clock enable is not a new bus rise
        REG_CLK_EN && $past(CE) |-> BUS_CLK && !$past(BUS_CLK);
    endproperty
    a_reg_strobe: assert property (p_reg_strobe) else $error("strobe off bus rise");

    property p_core_fll;
        core_sel == clock_dist_pkg::CORE_FLL && CE |=> CPU_CLK == $past(FLL_CLK);
    endproperty
    a_core_fll: assert property (p_core_fll) else $error("fll not routed");

    property p_dbg_off;
        !dbg_ok && CE |=> !DEBUG_FAST_CLK && !DEBUG_CLK_VALID;
    endproperty
    a_dbg_off: assert property (p_dbg_off) else $error("debug clock on fll");

    property p_adc_ext;
        adc_sel_q && CE |=> ADC_ALT_CLK == $past(EXT_REF_CLK);
    endproperty
    a_adc_ext: assert property (p_adc_ext) else $error("adc alt clock wrong");

    property p_day_int;
        day_sel_q == clock_dist_pkg::DAY_INT_REF && CE |=> DAY_CLK == $past(INT_REF_CLK);
    endproperty
    a_day_int: assert property (p_day_int) else $error("day int ref wrong");

    property p_ff_sync;
        $changed(fixed_freq_clock_q) |-> $past(regen_d);
    endproperty
    a_ff_sync: assert property (p_ff_sync) else $error("fixed clock off bus edge");

    property p_wdog_lpo;
        !wdog_sel_q && CE |=> WDOG_CLK == $past(LOW_POWER_OSC);
    endproperty
    a_wdog_lpo: assert property (p_wdog_lpo) else $error("watchdog lpo wrong");

    property p_disp_xtal;
        !disp_sel_q && CE |=> DISPLAY_CLK == $past(CRYSTAL_OSC);
    endproperty
    a_disp_xtal: assert property (p_disp_xtal) else $error("display crystal wrong");

    property p_day_out_gate;
        !DAY_CLK_OUT_EN && CE |=> !DAY_OUT_CLK;
    endproperty
    a_day_out_gate: assert property (p_day_out_gate) else $error("derived clock ungated");

    property p_timer_sel_hold;
        TIMER_EN && CE |=> $stable(timer_sel_q);
    endproperty
    a_timer_sel_hold: assert property (p_timer_sel_hold) else $error("timer sel changed");

    property p_wdog_bus;
        wdog_sel_q && CE |=> WDOG_CLK == $past(BUS_CLK);
    endproperty
    a_wdog_bus: assert property (p_wdog_bus) else $error("watchdog bus clock wrong");

    property p_timer_ext;
        timer_sel_q == clock_dist_pkg::TIMER_EXT && CE |=> TIMER_CLK == $past(tx_s2_q);
    endproperty
    a_timer_ext: assert property (p_timer_ext) else $error("timer pin clock wrong");

    property p_day_out_follow;
        DAY_CLK_OUT_EN && DAY_EN && CE |=> DAY_OUT_CLK == $past(DAY_CLK);
    endproperty
    a_day_out_follow: assert property (p_day_out_follow) else $error("derived clock lost");

endmodule : system_clock_distribution

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       CLK_SYS         = 1'h0;
    logic       SYS_RST         = 1'h1;
    logic       CE              = 1'h1;
    logic       INT_REF_CLK     = 1'h0;
    logic       EXT_REF_CLK     = 1'h0;
    logic       FLL_CLK         = 1'h0;
    logic [1:0] CORE_SRC_SEL    = 2'h0;
    logic       DIG_OSC_CLK     = 1'h0;
    logic       FIXED_RAW_CLK   = 1'h0;
    logic       LOW_POWER_OSC   = 1'h0;
    logic       CRYSTAL_OSC     = 1'h0;
    logic       TIMER_EXT_IN    = 1'h0;
    logic       ADC_EN          = 1'h0;
    logic       ADC_SRC_SEL     = 1'h0;
    logic       DAY_EN          = 1'h0;
    logic [1:0] DAY_SRC_SEL     = 2'h0;
    logic       DAY_CLK_OUT_EN  = 1'h0;
    logic       WDOG_EN         = 1'h0;
    logic       WDOG_SRC_SEL    = 1'h0;
    logic       TIMER_EN        = 1'h0;
    logic [1:0] TIMER_SRC_SEL   = 2'h0;
    logic       DISPLAY_EN      = 1'h0;
    logic       DISPLAY_SRC_SEL = 1'h0;
    logic       CPU_CLK, BUS_CLK, REG_CLK_EN, DEBUG_FAST_CLK, DEBUG_CLK_VALID, ADC_ALT_CLK;
    logic       DAY_CLK, DAY_OUT_CLK, WDOG_CLK, TIMER_CLK, DISPLAY_CLK;
    logic       run_fll         = 1'h0;
    int         errors          = 0;
    int         cmp_count       = 0;
    int         cycles          = 0;

    system_clock_distribution dut_u (
        .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE), .INT_REF_CLK(INT_REF_CLK),
        .EXT_REF_CLK(EXT_REF_CLK), .FLL_CLK(FLL_CLK), .CORE_SRC_SEL(CORE_SRC_SEL),
        .DIG_OSC_CLK(DIG_OSC_CLK), .FIXED_RAW_CLK(FIXED_RAW_CLK), .LOW_POWER_OSC(LOW_POWER_OSC),
        .CRYSTAL_OSC(CRYSTAL_OSC), .TIMER_EXT_IN(TIMER_EXT_IN), .ADC_EN(ADC_EN),
        .ADC_SRC_SEL(ADC_SRC_SEL), .DAY_EN(DAY_EN), .DAY_SRC_SEL(DAY_SRC_SEL),
        .DAY_CLK_OUT_EN(DAY_CLK_OUT_EN), .WDOG_EN(WDOG_EN), .WDOG_SRC_SEL(WDOG_SRC_SEL),
        .TIMER_EN(TIMER_EN), .TIMER_SRC_SEL(TIMER_SRC_SEL), .DISPLAY_EN(DISPLAY_EN),
        .DISPLAY_SRC_SEL(DISPLAY_SRC_SEL), .CPU_CLK(CPU_CLK), .BUS_CLK(BUS_CLK),
        .REG_CLK_EN(REG_CLK_EN), .DEBUG_FAST_CLK(DEBUG_FAST_CLK),
        .DEBUG_CLK_VALID(DEBUG_CLK_VALID), .ADC_ALT_CLK(ADC_ALT_CLK), .DAY_CLK(DAY_CLK),
        .DAY_OUT_CLK(DAY_OUT_CLK), .WDOG_CLK(WDOG_CLK), .TIMER_CLK(TIMER_CLK),
        .DISPLAY_CLK(DISPLAY_CLK)
    );

    initial forever #2 CLK_SYS = ~CLK_SYS;

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // whole run needs about 285 cycles
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            $display("unexpected hang at %0t", $time);
            test_done();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // inputs always move 1 ns after the rising edge; free fll gives a running bus clock
    task automatic tick;
        @(posedge CLK_SYS);
        #1;
        if (run_fll)
            FLL_CLK = ~FLL_CLK;
    endtask : tick

    task automatic t_core;
        int   rises;
        int   pulses;
        logic s;
        logic ns;
        logic b;
        run_fll = 1'h0;
        for (int sel = 0; sel < 4; sel++) begin
            CORE_SRC_SEL = 2'(sel);
            rises = 0;
            pulses = 0;
            for (int i = 0; i < 9; i++) begin
                s = i[0];
                ns = ~s;
                // unselected sources run inverted so any leak shows
                INT_REF_CLK = (sel == 0 || sel == 3) ? s : ns;
                EXT_REF_CLK = (sel == 1) ? s : ns;
                FLL_CLK = (sel == 2) ? s : ns;
                DIG_OSC_CLK = ns;
                b = BUS_CLK;
                tick();
                chk({7'h0, CPU_CLK}, {7'h0, s});
                if (BUS_CLK !== b)
                    rises++;
                if (REG_CLK_EN === 1'h1)
                    pulses++;
                chk({7'h0, DEBUG_CLK_VALID}, {7'h0, sel < 2});
                if (sel < 2)
                    chk({7'h0, DEBUG_FAST_CLK}, {7'h0, ns});
            end
            chk(8'(rises), 8'h04);
            chk(8'(pulses), 8'h02);
        end
        $display("core test finished, mismatches %0d", errors);
    endtask : t_core

    task automatic t_periph;
        logic [3:0] v;
        logic [1:0] day_h;
        logic       exp_day;
        logic       outen;
        logic       exp_out;
        logic       exp_disp;
        run_fll = 1'h1;
        for (int ds = 0; ds < 2; ds++) begin
            for (int d = 0; d < 3; d++) begin
                {ADC_EN, DAY_EN, WDOG_EN, DISPLAY_EN} = 4'h0;
                ADC_SRC_SEL = 1'h1;
                DAY_SRC_SEL = 2'(d);
                WDOG_SRC_SEL = 1'h0;
                DISPLAY_SRC_SEL = ds[0];
                outen = !(d == 2 && ds == 0);
                DAY_CLK_OUT_EN = outen;
                tick();
                tick();
                {ADC_EN, DAY_EN, WDOG_EN, DISPLAY_EN} = 4'hf;
                // must be ignored while the day counter is enabled
                DAY_SRC_SEL = 2'((d + 1) % 3);
                day_h = 2'h0;
                for (int i = 0; i < 16; i++) begin
                    v = 4'(i * 5);
                    {EXT_REF_CLK, CRYSTAL_OSC, LOW_POWER_OSC, INT_REF_CLK} = v;
                    exp_day = v[d];
                    exp_out = outen & day_h[0];
                    exp_disp = ds[0] ? day_h[1] : v[2];
                    tick();
                    if (i > 2) begin
                        chk({7'h0, DAY_CLK}, {7'h0, exp_day});
                        chk({7'h0, ADC_ALT_CLK}, {7'h0, v[3]});
                        chk({7'h0, WDOG_CLK}, {7'h0, v[1]});
                        chk({7'h0, DAY_OUT_CLK}, {7'h0, exp_out});
                        chk({7'h0, DISPLAY_CLK}, {7'h0, exp_disp});
                    end
                    day_h = {day_h[0], exp_day};
                end
            end
        end
        $display("peripheral routing test finished, mismatches %0d", errors);
    endtask : t_periph

    task automatic t_timer;
        int   n;
        logic e;
        logic ne;
        run_fll = 1'h1;
        // fixed clock only loads on bus rises, so the bus must run from the fll
        CORE_SRC_SEL = 2'h2;
        TIMER_EN = 1'h0;
        TIMER_SRC_SEL = 2'h2;
        repeat (20) tick();
        TIMER_EN = 1'h1;
        for (int k = 0; k < 4; k++) begin
            // pin period 32 cycles keeps it well under a quarter of the bus clock
            TIMER_EXT_IN = ~TIMER_EXT_IN;
            e = TIMER_EXT_IN;
            ne = ~e;
            tick();
            tick();
            chk({7'h0, TIMER_CLK}, {7'h0, ne});
            tick();
            chk({7'h0, TIMER_CLK}, {7'h0, e});
            repeat (13) tick();
        end
        TIMER_EN = 1'h0;
        TIMER_SRC_SEL = 2'h1;
        repeat (2) tick();
        TIMER_EN = 1'h1;
        repeat (10) tick();
        chk({7'h0, TIMER_CLK}, 8'h00);
        FIXED_RAW_CLK = 1'h1;
        n = 0;
        while (TIMER_CLK !== 1'h1 && n < 12) begin
            tick();
            n++;
        end
        // two sync flops plus wait for a bus rise bound the latency
        chk({7'h0, n >= 3 && n <= 8}, 8'h01);
        $display("timer test finished, mismatches %0d", errors);
    endtask : t_timer

    task automatic t_bus_src;
        logic b;
        run_fll = 1'h1;
        CORE_SRC_SEL = 2'h2;
        {ADC_EN, WDOG_EN, TIMER_EN} = 3'h0;
        ADC_SRC_SEL = 1'h0;
        WDOG_SRC_SEL = 1'h1;
        TIMER_SRC_SEL = 2'h0;
        repeat (2) tick();
        {ADC_EN, WDOG_EN, TIMER_EN} = 3'h7;
        for (int i = 0; i < 12; i++) begin
            b = BUS_CLK;
            tick();
            chk({7'h0, ADC_ALT_CLK}, {7'h0, b});
            chk({7'h0, WDOG_CLK}, {7'h0, b});
            chk({7'h0, TIMER_CLK}, {7'h0, b});
        end
        $display("bus source test finished, mismatches %0d", errors);
    endtask : t_bus_src

    task automatic t_freeze;
        logic b;
        run_fll = 1'h0;
        CORE_SRC_SEL = 2'h0;
        INT_REF_CLK = 1'h1;
        tick();
        b = BUS_CLK;
        CE = 1'h0;
        INT_REF_CLK = 1'h0;
        repeat (3) tick();
        chk({7'h0, CPU_CLK}, 8'h01);
        chk({7'h0, BUS_CLK}, {7'h0, b});
        CE = 1'h1;
        tick();
        chk({7'h0, CPU_CLK}, 8'h00);
        $display("clock enable test finished, mismatches %0d", errors);
    endtask : t_freeze

    initial begin
        repeat (20) @(posedge CLK_SYS);
        #1;
        chk({7'h0, |{CPU_CLK, BUS_CLK, REG_CLK_EN, DEBUG_FAST_CLK, DEBUG_CLK_VALID,
                     ADC_ALT_CLK, DAY_CLK, DAY_OUT_CLK, WDOG_CLK, TIMER_CLK, DISPLAY_CLK}},
            8'h00);
        SYS_RST = 1'h0;
        t_core();
        t_periph();
        t_bus_src();
        t_timer();
        t_freeze();
        test_done();
    end
endmodule : tb_top
